// ### verilog/bsa_pkg.sv
package bsa_pkg;

  localparam int unsigned SLICE_W  = 2;
  localparam int unsigned NUM_REGS = 12;
  localparam int unsigned IDX_W    = 4;

  typedef enum logic [2:0] {
    FG_0 = 3'h0,
    FG_1 = 3'h1,
    FG_2 = 3'h2,
    FG_3 = 3'h3,
    FG_4 = 3'h4,
    FG_5 = 3'h5,
    FG_6 = 3'h6,
    FG_7 = 3'h7
  } bsa_fgroup_t;

  typedef enum logic [1:0] {
    RG_I   = 2'h0,
    RG_II  = 2'h1,
    RG_III = 2'h2
  } bsa_rgroup_t;

  localparam logic [IDX_W-1:0]   IDX_T       = 4'ha;
  localparam logic [IDX_W-1:0]   IDX_AC      = 4'hb;
  localparam logic [IDX_W-1:0]   SEL_LAST_I  = 4'hb;
  localparam logic [IDX_W-1:0]   SEL_II_T    = 4'hd;
  localparam logic [IDX_W-1:0]   SEL_LAST_II = 4'hd;
  localparam logic [IDX_W-1:0]   SEL_III_T   = 4'hf;

  localparam logic [SLICE_W-1:0] K_ZEROS     = 2'h0;
  localparam logic [SLICE_W-1:0] K_ONES      = 2'h3;
  localparam logic [SLICE_W-1:0] ZERO_WORD   = 2'h0;
  localparam logic [SLICE_W-1:0] RESET_WORD  = 2'h0;

endpackage : bsa_pkg

// ### verilog/bsa_adder.sv
`timescale 1ns/10ps
module bsa_adder
(
  // Operands
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_addend_a,
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_addend_b,
  input  wire logic                        i_carry_in,
  // Result
  output      logic [bsa_pkg::SLICE_W-1:0] o_sum,
  output      logic                        o_carry_out
);

  logic [bsa_pkg::SLICE_W:0] wide_sum;

  always_comb
  begin
    wide_sum    = {1'b0, i_addend_a} + {1'b0, i_addend_b} + {{bsa_pkg::SLICE_W{1'b0}}, i_carry_in};
    o_sum       = wide_sum[bsa_pkg::SLICE_W-1:0];
    o_carry_out = wide_sum[bsa_pkg::SLICE_W];
  end

endmodule : bsa_adder

// ### verilog/bsa_reg_file.sv
`timescale 1ns/10ps
module bsa_reg_file
(
  // Clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  // Write port
  input  wire logic                          i_write_en,
  input  wire logic [bsa_pkg::IDX_W-1:0]     i_write_idx,
  input  wire logic [bsa_pkg::SLICE_W-1:0]   i_write_data,
  // All entries, scratch 0..9, T, accumulator
  output      logic [bsa_pkg::SLICE_W-1:0]   o_entries [bsa_pkg::NUM_REGS]
);

  genvar g;
  generate
    for (g = 0; g < bsa_pkg::NUM_REGS; g++)
    begin : g_entry
      logic [bsa_pkg::SLICE_W-1:0] entry_r;
      logic [bsa_pkg::SLICE_W-1:0] entry_nxt;

      always_comb
      begin
        entry_nxt = entry_r;
        if (i_write_en && (i_write_idx == bsa_pkg::IDX_W'(g)))
        begin
          entry_nxt = i_write_data;
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          entry_r <= bsa_pkg::RESET_WORD;
        end
        else
        begin
          entry_r <= entry_nxt;
        end
      end

      assign o_entries[g] = entry_r;
    end
  endgenerate

endmodule : bsa_reg_file

// ### verilog/bsa_slice.sv
`timescale 1ns/10ps
module bsa_slice
(
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset_n,
  // Microinstruction function code
  input  wire logic [2:0]                  i_func_group,
  input  wire logic [bsa_pkg::IDX_W-1:0]   i_reg_sel,
  // Data buses
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_port_bus,
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_literal_bus,
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_memory_bus,
  // Carry chain
  input  wire logic                        i_carry_input,
  output      logic                        o_carry_output,
  // Accumulator data bus
  output      logic [bsa_pkg::SLICE_W-1:0] o_accum_bus
);

  bsa_pkg::bsa_fgroup_t          fgroup;
  bsa_pkg::bsa_rgroup_t          rgroup;
  logic [bsa_pkg::IDX_W-1:0]     at_idx;
  logic [bsa_pkg::IDX_W-1:0]     dest_idx;
  logic [bsa_pkg::SLICE_W-1:0]   entries [bsa_pkg::NUM_REGS];
  logic [bsa_pkg::SLICE_W-1:0]   rn_val;
  logic [bsa_pkg::SLICE_W-1:0]   at_val;
  logic [bsa_pkg::SLICE_W-1:0]   ac_val;
  logic [bsa_pkg::SLICE_W-1:0]   ac_lit;
  logic [bsa_pkg::SLICE_W-1:0]   port_lit;
  logic [bsa_pkg::SLICE_W-1:0]   add_sum;
  logic                          add_cout;
  logic [bsa_pkg::SLICE_W-1:0]   result;
  logic                          write_en;
  logic                          carry_out;

  // Register selection decode
  always_comb
  begin
    fgroup = bsa_pkg::bsa_fgroup_t'(i_func_group);
    if (i_reg_sel <= bsa_pkg::SEL_LAST_I)
    begin
      rgroup = bsa_pkg::RG_I;
    end
    else if (i_reg_sel <= bsa_pkg::SEL_LAST_II)
    begin
      rgroup = bsa_pkg::RG_II;
    end
    else
    begin
      rgroup = bsa_pkg::RG_III;
    end
    if ((i_reg_sel == bsa_pkg::SEL_II_T) || (i_reg_sel == bsa_pkg::SEL_III_T))
    begin
      at_idx = bsa_pkg::IDX_T;
    end
    else
    begin
      at_idx = bsa_pkg::IDX_AC;
    end
    dest_idx = (rgroup == bsa_pkg::RG_I) ? i_reg_sel : at_idx;
  end

  // Operand fetch; R group II/III codes never index a scratch entry
  always_comb
  begin
    rn_val   = (rgroup == bsa_pkg::RG_I) ? entries[i_reg_sel] : bsa_pkg::ZERO_WORD;
    at_val   = entries[at_idx];
    ac_val   = entries[bsa_pkg::IDX_AC];
    ac_lit   = ac_val & i_literal_bus;
    port_lit = i_port_bus & i_literal_bus;
  end

  bsa_adder u_adder
  (
    .i_addend_a  (at_val),
    .i_addend_b  (port_lit),
    .i_carry_in  (i_carry_input),
    .o_sum       (add_sum),
    .o_carry_out (add_cout)
  );

  // Function execution. The literal bus acts as a mask, so the 00 and 11
  // special cases fall out of the general masked equations exactly.
  always_comb
  begin
    result    = rn_val;
    write_en  = 1'b0;
    carry_out = i_carry_input;
    unique case (fgroup)
      bsa_pkg::FG_0, bsa_pkg::FG_1, bsa_pkg::FG_2:
      begin
        write_en = 1'b0;
      end
      bsa_pkg::FG_3:
      begin
        if (rgroup == bsa_pkg::RG_III)
        begin
          result    = add_sum;
          carry_out = add_cout;
          write_en  = 1'b1;
        end
      end
      bsa_pkg::FG_4:
      begin
        unique case (rgroup)
          bsa_pkg::RG_I:   result = rn_val & ac_lit;
          bsa_pkg::RG_II:  result = i_memory_bus & ac_lit;
          bsa_pkg::RG_III: result = at_val & port_lit;
          default:         result = bsa_pkg::ZERO_WORD;
        endcase
        carry_out = i_carry_input | (|result);
        write_en  = 1'b1;
      end
      bsa_pkg::FG_5:
      begin
        unique case (rgroup)
          bsa_pkg::RG_I:   result = i_literal_bus & rn_val;
          bsa_pkg::RG_II:  result = i_literal_bus & i_memory_bus;
          bsa_pkg::RG_III: result = i_literal_bus & at_val;
          default:         result = bsa_pkg::ZERO_WORD;
        endcase
        carry_out = i_carry_input | (|result);
        write_en  = 1'b1;
      end
      bsa_pkg::FG_6:
      begin
        unique case (rgroup)
          bsa_pkg::RG_I:
          begin
            result    = rn_val | ac_lit;
            carry_out = i_carry_input | (|ac_lit);
          end
          bsa_pkg::RG_II:
          begin
            result    = i_memory_bus | ac_lit;
            carry_out = i_carry_input | (|ac_lit);
          end
          bsa_pkg::RG_III:
          begin
            result    = at_val | port_lit;
            carry_out = i_carry_input | (|port_lit);
          end
          default:
          begin
            result    = bsa_pkg::ZERO_WORD;
            carry_out = i_carry_input;
          end
        endcase
        write_en = 1'b1;
      end
      bsa_pkg::FG_7:
      begin
        if (rgroup == bsa_pkg::RG_I)
        begin
          result    = ~(rn_val ^ ac_lit);
          carry_out = i_carry_input | (|(rn_val & ac_lit));
          write_en  = 1'b1;
        end
      end
    endcase
  end

  // Carry is combinational so a cascade ripples inside one cycle
  assign o_carry_output = carry_out;
  assign o_accum_bus    = entries[bsa_pkg::IDX_AC];

  bsa_reg_file u_reg_file
  (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_write_en   (write_en),
    .i_write_idx  (dest_idx),
    .i_write_data (result),
    .o_entries    (entries)
  );

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_add_sum;
    (fgroup == bsa_pkg::FG_3) && (rgroup == bsa_pkg::RG_III)
      |=> entries[$past(at_idx)] == 2'($past(at_val) + $past(port_lit) + {1'b0, $past(i_carry_input)});
  endproperty
  a_add_sum : assert property (p_add_sum) else $error("add result not written");

  property p_increment;
    (fgroup == bsa_pkg::FG_3) && (rgroup == bsa_pkg::RG_III) && (i_literal_bus == bsa_pkg::K_ZEROS)
      |=> entries[$past(at_idx)] == 2'($past(at_val) + {1'b0, $past(i_carry_input)});
  endproperty
  a_increment : assert property (p_increment) else $error("increment wrong");

  property p_and_scratch;
    (fgroup == bsa_pkg::FG_4) && (rgroup == bsa_pkg::RG_I)
      |-> (o_carry_output == (i_carry_input | (|(rn_val & ac_val & i_literal_bus))))
      ##1 (entries[$past(i_reg_sel)] == ($past(rn_val) & $past(ac_val) & $past(i_literal_bus)));
  endproperty
  a_and_scratch : assert property (p_and_scratch) else $error("scratch AND wrong");

  property p_clear;
    ((fgroup == bsa_pkg::FG_4) || (fgroup == bsa_pkg::FG_5)) && (i_literal_bus == bsa_pkg::K_ZEROS)
      |-> (o_carry_output == i_carry_input) ##1 (entries[$past(dest_idx)] == bsa_pkg::ZERO_WORD);
  endproperty
  a_clear : assert property (p_clear) else $error("clear failed");

  property p_and_memory;
    (fgroup == bsa_pkg::FG_4) && (rgroup == bsa_pkg::RG_II)
      |=> entries[$past(at_idx)] == ($past(i_memory_bus) & $past(ac_val) & $past(i_literal_bus));
  endproperty
  a_and_memory : assert property (p_and_memory) else $error("memory AND wrong");

  property p_test_scratch;
    (fgroup == bsa_pkg::FG_5) && (rgroup == bsa_pkg::RG_I) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|rn_val))) ##1 (entries[$past(i_reg_sel)] == $past(rn_val));
  endproperty
  a_test_scratch : assert property (p_test_scratch) else $error("scratch test wrong");

  property p_load_memory;
    (fgroup == bsa_pkg::FG_5) && (rgroup == bsa_pkg::RG_II) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|i_memory_bus)))
      ##1 (entries[$past(at_idx)] == $past(i_memory_bus));
  endproperty
  a_load_memory : assert property (p_load_memory) else $error("memory load wrong");

  property p_null_op;
    (fgroup == bsa_pkg::FG_6) && (rgroup != bsa_pkg::RG_II) && (i_literal_bus == bsa_pkg::K_ZEROS)
      |-> (o_carry_output == i_carry_input) ##1 (entries[$past(dest_idx)] == $past(entries[dest_idx]));
  endproperty
  a_null_op : assert property (p_null_op) else $error("null operation changed state");

  property p_or_memory_prior_ac;
    (fgroup == bsa_pkg::FG_6) && (rgroup == bsa_pkg::RG_II) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|ac_val)))
      ##1 (entries[$past(at_idx)] == ($past(i_memory_bus) | $past(ac_val)));
  endproperty
  a_or_memory_prior_ac : assert property (p_or_memory_prior_ac) else $error("OR memory wrong");

  property p_or_port;
    (fgroup == bsa_pkg::FG_6) && (rgroup == bsa_pkg::RG_III)
      |-> o_carry_output == (i_carry_input | (|(i_port_bus & i_literal_bus)));
  endproperty
  a_or_port : assert property (p_or_port) else $error("OR port carry wrong");

  property p_complement;
    (fgroup == bsa_pkg::FG_7) && (rgroup == bsa_pkg::RG_I) && (i_literal_bus == bsa_pkg::K_ZEROS)
      |-> (o_carry_output == i_carry_input) ##1 (entries[$past(i_reg_sel)] == ~$past(rn_val));
  endproperty
  a_complement : assert property (p_complement) else $error("complement wrong");

  property p_xnor_scratch;
    (fgroup == bsa_pkg::FG_7) && (rgroup == bsa_pkg::RG_I) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|(rn_val & ac_val))))
      ##1 (entries[$past(i_reg_sel)] == ~($past(rn_val) ^ $past(ac_val)));
  endproperty
  a_xnor_scratch : assert property (p_xnor_scratch) else $error("XNOR wrong");

  property p_idle_groups;
    (fgroup == bsa_pkg::FG_0) || (fgroup == bsa_pkg::FG_1) || (fgroup == bsa_pkg::FG_2)
      |-> (o_carry_output == i_carry_input) ##1 $stable(o_accum_bus);
  endproperty
  a_idle_groups : assert property (p_idle_groups) else $error("unhandled group changed state");

  // Partly covered groups must not leak a write or a stray carry
  property p_refused;
    ((fgroup == bsa_pkg::FG_3) && (rgroup != bsa_pkg::RG_III)) ||
    ((fgroup == bsa_pkg::FG_7) && (rgroup != bsa_pkg::RG_I))
      |-> (o_carry_output == i_carry_input) ##1 $stable(o_accum_bus);
  endproperty
  a_refused : assert property (p_refused) else $error("refused group acted");

  property p_and_port;
    (fgroup == bsa_pkg::FG_4) && (rgroup == bsa_pkg::RG_III)
      |-> (o_carry_output == (i_carry_input | (|(at_val & i_port_bus & i_literal_bus))))
      ##1 (entries[$past(at_idx)] == ($past(at_val) & $past(i_port_bus) & $past(i_literal_bus)));
  endproperty
  a_and_port : assert property (p_and_port) else $error("port AND wrong");

  property p_mask_accum;
    (fgroup == bsa_pkg::FG_5) && (rgroup == bsa_pkg::RG_III)
      |-> (o_carry_output == (i_carry_input | (|(at_val & i_literal_bus))))
      ##1 (entries[$past(at_idx)] == ($past(at_val) & $past(i_literal_bus)));
  endproperty
  a_mask_accum : assert property (p_mask_accum) else $error("masked accumulator wrong");

  property p_test_accum;
    (fgroup == bsa_pkg::FG_5) && (rgroup == bsa_pkg::RG_III) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|at_val))) ##1 (entries[$past(at_idx)] == $past(at_val));
  endproperty
  a_test_accum : assert property (p_test_accum) else $error("accumulator test wrong");

  property p_or_scratch;
    (fgroup == bsa_pkg::FG_6) && (rgroup == bsa_pkg::RG_I)
      |-> (o_carry_output == (i_carry_input | (|(ac_val & i_literal_bus))))
      ##1 (entries[$past(i_reg_sel)] == ($past(rn_val) | ($past(ac_val) & $past(i_literal_bus))));
  endproperty
  a_or_scratch : assert property (p_or_scratch) else $error("scratch OR wrong");

  property p_plain_load;
    (fgroup == bsa_pkg::FG_6) && (rgroup == bsa_pkg::RG_II) && (i_literal_bus == bsa_pkg::K_ZEROS)
      |-> (o_carry_output == i_carry_input) ##1 (entries[$past(at_idx)] == $past(i_memory_bus));
  endproperty
  a_plain_load : assert property (p_plain_load) else $error("plain memory load wrong");

  property p_or_port_ones;
    (fgroup == bsa_pkg::FG_6) && (rgroup == bsa_pkg::RG_III) && (i_literal_bus == bsa_pkg::K_ONES)
      |-> (o_carry_output == (i_carry_input | (|i_port_bus)))
      ##1 (entries[$past(at_idx)] == ($past(at_val) | $past(i_port_bus)));
  endproperty
  a_or_port_ones : assert property (p_or_port_ones) else $error("port OR wrong");

  property p_xnor_masked;
    (fgroup == bsa_pkg::FG_7) && (rgroup == bsa_pkg::RG_I)
      |-> (o_carry_output == (i_carry_input | (|(rn_val & ac_val & i_literal_bus))))
      ##1 (entries[$past(i_reg_sel)] == ~($past(rn_val) ^ ($past(ac_val) & $past(i_literal_bus))));
  endproperty
  a_xnor_masked : assert property (p_xnor_masked) else $error("masked XNOR wrong");

endmodule : bsa_slice

// ### dv/bsa_nbr_slice.sv
`timescale 1ns/10ps
module bsa_nbr_slice
(
  // Neighbour slice state
  input  wire logic [bsa_pkg::SLICE_W-1:0] i_slice_val,
  input  wire logic                        i_carry_input,
  // Carry chain towards the slice under test
  output      logic                        o_carry_output
);
  // Word-wise OR chain of the lower slice
  assign o_carry_output = i_carry_input | (|i_slice_val);
endmodule : bsa_nbr_slice

// ### dv/bsa_slice_tb.sv
`timescale 1ns/10ps
module bsa_slice_tb;
  logic                        i_sys_clk;
  logic                        i_reset_n;
  logic [2:0]                  i_func_group;
  logic [bsa_pkg::IDX_W-1:0]   i_reg_sel;
  logic [bsa_pkg::SLICE_W-1:0] i_port_bus;
  logic [bsa_pkg::SLICE_W-1:0] i_literal_bus;
  logic [bsa_pkg::SLICE_W-1:0] i_memory_bus;
  logic                        i_carry_input;
  logic                        o_carry_output;
  logic [bsa_pkg::SLICE_W-1:0] o_accum_bus;
  logic [bsa_pkg::SLICE_W-1:0] nbr_val;
  logic                        nbr_ci;
  int                          mismatches;
  int                          checks_done;
  logic [31:0]                 lfsr;
  logic [bsa_pkg::SLICE_W-1:0] model_regs [bsa_pkg::NUM_REGS];
  logic [bsa_pkg::SLICE_W-1:0] exp_wr;
  logic                        exp_we;
  logic                        exp_co;
  logic [bsa_pkg::IDX_W-1:0]   exp_dst;
  logic [bsa_pkg::IDX_W-1:0]   sel_tab [4];

  bsa_slice u_bsa_slice (
    .i_sys_clk      (i_sys_clk),
    .i_reset_n      (i_reset_n),
    .i_func_group   (i_func_group),
    .i_reg_sel      (i_reg_sel),
    .i_port_bus     (i_port_bus),
    .i_literal_bus  (i_literal_bus),
    .i_memory_bus   (i_memory_bus),
    .i_carry_input  (i_carry_input),
    .o_carry_output (o_carry_output),
    .o_accum_bus    (o_accum_bus)
  );

  bsa_nbr_slice u_bsa_nbr_slice (
    .i_slice_val    (nbr_val),
    .i_carry_input  (nbr_ci),
    .o_carry_output (i_carry_input)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_step

  // Selects 12..15 map onto AC/T, odd codes pick T
  function automatic logic [3:0] dst_of(input logic [3:0] sel);
    return (sel < 4'hc) ? sel : (sel[0] ? bsa_pkg::IDX_T : bsa_pkg::IDX_AC);
  endfunction : dst_of

  function automatic logic [1:0] rg_of(input logic [3:0] sel);
    return (sel < 4'hc) ? 2'h0 : ((sel < 4'he) ? 2'h1 : 2'h2);
  endfunction : rg_of

  task automatic compute_expected();
    logic [1:0] at;
    logic [1:0] ac;
    logic [1:0] t;
    logic [1:0] rg;
    logic [2:0] sum;
    rg = rg_of(i_reg_sel);
    exp_dst = dst_of(i_reg_sel);
    at = model_regs[exp_dst];
    ac = model_regs[bsa_pkg::IDX_AC];
    exp_we = 1'b1;
    exp_co = i_carry_input;
    exp_wr = at;
    case (i_func_group)
      3'h3:
      begin
        sum = {1'b0, at} + {1'b0, i_port_bus & i_literal_bus} + {2'h0, i_carry_input};
        exp_wr = sum[1:0];
        exp_co = (rg == 2'h2) ? sum[2] : i_carry_input;
        exp_we = (rg == 2'h2);
      end
      3'h4:
      begin
        t = (rg == 2'h0) ? (at & ac) : ((rg == 2'h1) ? (i_memory_bus & ac) : (at & i_port_bus));
        exp_wr = t & i_literal_bus;
        exp_co = i_carry_input | (|exp_wr);
      end
      3'h5:
      begin
        exp_wr = i_literal_bus & ((rg == 2'h1) ? i_memory_bus : at);
        exp_co = i_carry_input | (|exp_wr);
      end
      3'h6:
      begin
        t = (rg == 2'h2) ? (i_port_bus & i_literal_bus) : (ac & i_literal_bus);
        exp_wr = ((rg == 2'h1) ? i_memory_bus : at) | t;
        exp_co = i_carry_input | (|t);
      end
      3'h7:
      begin
        exp_wr = ~(at ^ (ac & i_literal_bus));
        exp_co = (rg == 2'h0) ? (i_carry_input | (|(at & ac & i_literal_bus))) : i_carry_input;
        exp_we = (rg == 2'h0);
      end
      default: exp_we = 1'b0;
    endcase
  endtask : compute_expected

  task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Entered at a rising edge; leaves at the next one with the model updated
  task automatic run_cycle(input logic [2:0] g, input logic [3:0] sel, input logic [11:0] bits);
    i_func_group  <= g;
    i_reg_sel     <= sel;
    i_port_bus    <= bits[1:0];
    i_literal_bus <= bits[3:2];
    i_memory_bus  <= bits[5:4];
    nbr_val       <= bits[7:6];
    nbr_ci        <= bits[8];
    @(negedge i_sys_clk);
    compute_expected();
    check("carry_output", {1'b0, exp_co}, {1'b0, o_carry_output});
    check("accum_bus", model_regs[bsa_pkg::IDX_AC], o_accum_bus);
    @(posedge i_sys_clk);
    if (exp_we)
      model_regs[exp_dst] = exp_wr;
  endtask : run_cycle

  task automatic complete_run();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    $display("CHECK FAILED run_length expected end seen timeout");
    complete_run();
  end

  initial
  begin
    i_reset_n = 1'b0;
    i_func_group = 3'h0;
    i_reg_sel = 4'h0;
    i_port_bus = 2'h0;
    i_literal_bus = 2'h0;
    i_memory_bus = 2'h0;
    nbr_val = 2'h0;
    nbr_ci = 1'b0;
    mismatches = 0;
    checks_done = 0;
    lfsr = 32'h0000_6efc;
    sel_tab = '{4'h0, 4'hb, 4'hc, 4'he};
    foreach (model_regs[n]) model_regs[n] = bsa_pkg::RESET_WORD;
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    // Preload AC with ones so AND-based forms see live data
    run_cycle(3'h5, 4'hc, 12'h03c);
    for (int g = 3; g < 8; g++)
      for (int s = 0; s < 4; s++)
        for (int k = 0; k < 4; k++)
        begin
          lfsr = lfsr_step(lfsr);
          run_cycle(g[2:0], sel_tab[s], {lfsr[11:4], k[1:0], lfsr[1:0]});
        end
    repeat (3000)
    begin
      lfsr = lfsr_step(lfsr);
      run_cycle(lfsr[14:12], lfsr[18:15], lfsr[11:0]);
    end
    // Asynchronous reset in mid-run clears every register at once
    @(negedge i_sys_clk);
    i_reset_n <= 1'b0;
    #1;
    check("accum_bus_reset", bsa_pkg::RESET_WORD, o_accum_bus);
    foreach (model_regs[n]) model_regs[n] = bsa_pkg::RESET_WORD;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (200)
    begin
      lfsr = lfsr_step(lfsr);
      run_cycle(lfsr[14:12], lfsr[18:15], lfsr[11:0]);
    end
    complete_run();
  end
endmodule : bsa_slice_tb
